// [core/sps_consts.vh]
// Purpose: shared constants of the serial port block
// Assumes: included by bare name from the port design file only
// Notes: definitions only
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH

// =====================================================
// Transfer geometry
`define SPS_BITS_PER_BYTE 4'h8
`define SPS_BYTE_RST 8'h00

// =====================================================
// Master sequencer states, one-hot
`define SPS_ST_IDLE 3'h1
`define SPS_ST_LOW 3'h2
`define SPS_ST_HIGH 3'h4

`endif

// [core/sps_edge.v]
// Purpose: edge detector for a pin taken as synchronous to mclk
// Assumes: input already synchronous; reset is the released copy
// Notes: pulses last one mclk cycle
`timescale 1ns/10ps
`default_nettype none
module sps_edge #(
    parameter RST_LEVEL = 1'b0
) (
    input wire mclk,
    input wire rst_n,
    input wire din,
    output wire rise,
    output wire fall
);
    reg prev_r;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= RST_LEVEL;
        end else begin
            prev_r <= din;
        end
    end

    assign rise = din & ~prev_r;
    assign fall = ~din & prev_r;
endmodule // sps_edge
`default_nettype wire

// [core/sps_port.v]
// Purpose: SPI port, master or slave, clock modes 0 and 3
// Assumes: pins synchronous to mclk; control bits are plain ports
// Notes: one-byte transmit and receive holding registers
`timescale 1ns/10ps
`default_nettype none
`include "sps_consts.vh"
module sps_port (
    input wire mclk,
    input wire rstn,
    input wire slave_mode_select,
    input wire master_clock_mode_bit,
    input wire bit_order_sel,
    input wire data_direction_bit,
    input wire auto_clear_enable,
    input wire serial_clock_out_enable,
    input wire mosi_out_enable,
    input wire miso_out_enable,
    input wire [7:0] clock_divider_reg,
    input wire [7:0] slave_preset_reg,
    input wire data_wr,
    input wire [7:0] data_wdata,
    input wire data_rd,
    output wire [7:0] data_rdata,
    input wire byte_flag_clr,
    output wire tx_fifo_count,
    output wire rx_fifo_count,
    output wire idle_flag,
    output wire byte_complete_flag,
    input wire sck_i,
    output wire sck_o,
    output wire sck_oe,
    input wire mosi_i,
    output wire mosi_o,
    output wire mosi_oe,
    input wire miso_i,
    output wire miso_o,
    output wire miso_oe,
    input wire slave_chip_select_n
);
    // =====================================================
    // Reset release
    reg rst_a_r;
    reg rst_b_r;
    wire rst_n;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end
    assign rst_n = rst_b_r;

    // =====================================================
    // Slave pin edges
    wire s_rise;
    wire s_fall;
    wire cs_rise;
    wire cs_fall;

    sps_edge #(.RST_LEVEL(1'b0)) u_sck_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(sck_i),
        .rise(s_rise),
        .fall(s_fall)
    );

    sps_edge #(.RST_LEVEL(1'b1)) u_cs_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(slave_chip_select_n),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    // =====================================================
    // State
    reg [2:0] state_r;
    reg [7:0] div_cnt_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] tx_sh_r;
    reg [7:0] rx_sh_r;
    reg [7:0] tx_byte_r;
    reg tx_full_r;
    reg [7:0] rx_byte_r;
    reg rx_full_r;
    reg [7:0] rdata_r;
    reg flag_r;
    reg sck_r;
    reg rd_start_r;
    reg s_first_r;

    wire [7:0] half = (clock_divider_reg[7:1] == 7'h00) ? 8'h01 :
        {1'b0, clock_divider_reg[7:1]};
    wire tick = (div_cnt_r >= half - 8'h01);
    wire m_idle = (state_r == `SPS_ST_IDLE);
    wire m_start = ~slave_mode_select & m_idle &
        (tx_full_r | rd_start_r);
    wire in_bit = slave_mode_select ? mosi_i : miso_i;
    wire out_bit = bit_order_sel ? tx_sh_r[0] : tx_sh_r[7];
    wire [7:0] tx_shifted = bit_order_sel ? {1'b0, tx_sh_r[7:1]} :
        {tx_sh_r[6:0], 1'b0};
    wire [7:0] rx_shifted = bit_order_sel ? {in_bit, rx_sh_r[7:1]} :
        {rx_sh_r[6:0], in_bit};
    wire cs_act = ~slave_chip_select_n;
    wire m_rise = (state_r == `SPS_ST_LOW) & tick;
    wire m_fall = (state_r == `SPS_ST_HIGH) & tick &
        (bit_cnt_r != `SPS_BITS_PER_BYTE);
    wire m_done = (state_r == `SPS_ST_HIGH) & tick &
        (bit_cnt_r == `SPS_BITS_PER_BYTE);
    // Sample edge; slave also needs chip select to count
    wire samp = slave_mode_select ? (s_rise & cs_act) : m_rise;
    // No shift before the first sample, so mode 3 lead edge is harmless
    wire shft = slave_mode_select ?
        (s_fall & cs_act & (bit_cnt_r != 4'h0)) : m_fall;
    wire s_done = slave_mode_select & samp &
        (bit_cnt_r == `SPS_BITS_PER_BYTE - 4'h1);
    wire done = m_done | s_done;
    wire fifo_acc = data_wr | data_rd;
    // Byte written between slave bytes must go out in the very next byte
    wire s_load = slave_mode_select & cs_act & (bit_cnt_r == 4'h0) &
        tx_full_r & ~s_first_r & ~cs_fall;

    // =====================================================
    // Master sequencer and divider
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `SPS_ST_IDLE;
            div_cnt_r <= 8'h00;
            sck_r <= 1'b0;
        end else begin
            case (state_r)
                `SPS_ST_IDLE: begin
                    div_cnt_r <= 8'h00;
                    sck_r <= master_clock_mode_bit;
                    if (m_start) begin
                        state_r <= `SPS_ST_LOW;
                        sck_r <= 1'b0;
                    end
                end
                `SPS_ST_LOW: begin
                    div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
                    if (tick) begin
                        state_r <= `SPS_ST_HIGH;
                        sck_r <= 1'b1;
                    end
                end
                `SPS_ST_HIGH: begin
                    div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
                    if (m_done) begin
                        state_r <= `SPS_ST_IDLE;
                        sck_r <= master_clock_mode_bit;
                    end else if (tick) begin
                        state_r <= `SPS_ST_LOW;
                        sck_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= `SPS_ST_IDLE;
                    sck_r <= master_clock_mode_bit;
                end
            endcase
        end
    end

    // =====================================================
    // Shifters, holding registers, flags
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= 4'h0;
            tx_sh_r <= `SPS_BYTE_RST;
            rx_sh_r <= `SPS_BYTE_RST;
            tx_byte_r <= `SPS_BYTE_RST;
            tx_full_r <= 1'b0;
            rx_byte_r <= `SPS_BYTE_RST;
            rx_full_r <= 1'b0;
            rdata_r <= `SPS_BYTE_RST;
            flag_r <= 1'b0;
            rd_start_r <= 1'b0;
            s_first_r <= 1'b0;
        end else begin
            if (data_wr) begin
                tx_byte_r <= data_wdata;
                tx_full_r <= 1'b1;
            end
            if (data_rd) begin
                rdata_r <= rx_byte_r;
                rx_full_r <= 1'b0;
            end
            // Read-started transfer resends the last byte as filler
            if (data_rd & data_direction_bit & ~slave_mode_select) begin
                rd_start_r <= 1'b1;
            end else if (m_start) begin
                rd_start_r <= 1'b0;
            end
            if (m_start) begin
                tx_sh_r <= tx_byte_r;
                tx_full_r <= data_wr;
                bit_cnt_r <= 4'h0;
            end
            if (slave_mode_select & cs_fall) begin
                tx_sh_r <= slave_preset_reg;
                bit_cnt_r <= 4'h0;
                s_first_r <= 1'b1;
            end else if (slave_mode_select & cs_rise) begin
                bit_cnt_r <= 4'h0;
            end else if (samp) begin
                s_first_r <= 1'b0;
                rx_sh_r <= rx_shifted;
                bit_cnt_r <= s_done ? 4'h0 : bit_cnt_r + 4'h1;
                if (s_done & tx_full_r) begin
                    tx_sh_r <= tx_byte_r;
                    tx_full_r <= data_wr;
                end
            end else if (shft) begin
                tx_sh_r <= tx_shifted;
            end else if (s_load) begin
                tx_sh_r <= tx_byte_r;
                tx_full_r <= data_wr;
            end
            if (m_done) begin
                bit_cnt_r <= 4'h0;
            end
            if (done) begin
                rx_byte_r <= slave_mode_select ? rx_shifted : rx_sh_r;
                rx_full_r <= 1'b1;
            end
            // Set beats a clear arriving in the same cycle
            if (done) begin
                flag_r <= 1'b1;
            end else if (byte_flag_clr | (auto_clear_enable & fifo_acc)) begin
                flag_r <= 1'b0;
            end
        end
    end

    // =====================================================
    // Outputs
    assign data_rdata = rdata_r;
    assign tx_fifo_count = tx_full_r;
    assign rx_fifo_count = rx_full_r;
    assign byte_complete_flag = flag_r;
    assign idle_flag = slave_mode_select ? (bit_cnt_r == 4'h0) :
        m_idle;
    assign sck_o = sck_r;
    assign sck_oe = ~slave_mode_select & serial_clock_out_enable;
    assign mosi_o = out_bit;
    assign mosi_oe = ~slave_mode_select & mosi_out_enable;
    assign miso_o = out_bit;
    // Released bus when deselected keeps it shareable
    assign miso_oe = slave_mode_select ? (cs_act & miso_out_enable) :
        miso_out_enable;
endmodule // sps_port
`default_nettype wire

// [bench/sps_port_checker.sv]
// Purpose: assertions on the serial port flags and pins
// Assumes: controls change only while the port is idle
// Notes: transfer bound suits small clock divider values
`timescale 1ns/10ps
`default_nettype none
module sps_port_checker (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic slave_mode_select,
    input wire logic master_clock_mode_bit,
    input wire logic data_direction_bit,
    input wire logic auto_clear_enable,
    input wire logic miso_out_enable,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic byte_flag_clr,
    input wire logic rx_fifo_count,
    input wire logic idle_flag,
    input wire logic byte_complete_flag,
    input wire logic sck_o,
    input wire logic mosi_o,
    input wire logic miso_oe,
    input wire logic slave_chip_select_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // =========================================================
    // Master sequencing and slave miso enable
    a_wr_starts_xfer: assert property (
        !slave_mode_select && idle_flag && data_wr |-> ##[1:2] !idle_flag)
        else $error("write did not start a transfer");
    a_xfer_ends_bounded: assert property (
        !slave_mode_select && $fell(idle_flag) |-> ##[8:300] idle_flag)
        else $error("transfer did not finish in time");
    a_done_sets_flags: assert property (
        !slave_mode_select && $rose(idle_flag)
        |-> byte_complete_flag && rx_fifo_count)
        else $error("byte end without flag or rx count");
    a_flag_write_clear: assert property (
        !slave_mode_select && idle_flag && byte_flag_clr && !data_wr
        |=> !byte_complete_flag) else $error("byte flag not cleared");
    a_flag_auto_clear: assert property (
        !slave_mode_select && idle_flag && auto_clear_enable && data_rd
        |=> !byte_complete_flag) else $error("auto clear failed");
    a_read_starts_xfer: assert property (
        !slave_mode_select && idle_flag && data_direction_bit && data_rd
        |-> ##[1:2] !idle_flag) else $error("read did not start transfer");
    a_read_stays_quiet: assert property (
        !slave_mode_select && idle_flag && !data_direction_bit && data_rd
        && !data_wr && !$past(data_wr) |=> idle_flag)
        else $error("read started a transfer");
    a_sck_idle_level: assert property (
        !slave_mode_select && idle_flag && $past(idle_flag)
        && $stable(master_clock_mode_bit) |-> sck_o == master_clock_mode_bit)
        else $error("serial clock idle level wrong");
    a_mosi_stable_rise: assert property (
        !slave_mode_select && !idle_flag && $rose(sck_o) |-> $stable(mosi_o))
        else $error("mosi changed at sampling edge");
    a_slave_miso_drive: assert property (
        slave_mode_select
        |-> miso_oe == (!slave_chip_select_n && miso_out_enable))
        else $error("slave miso enable wrong");
endmodule // sps_port_checker
bind sps_port sps_port_checker u_chk (.mclk, .rstn, .slave_mode_select,
    .master_clock_mode_bit, .data_direction_bit, .auto_clear_enable,
    .miso_out_enable, .data_wr, .data_rd, .byte_flag_clr, .rx_fifo_count,
    .idle_flag, .byte_complete_flag, .sck_o, .mosi_o, .miso_oe,
    .slave_chip_select_n);
`default_nettype wire

// [bench/sps_peer.sv]
// Purpose: far-end serial slave for master mode runs
// Assumes: load pulses before each framed byte
// Notes: shifts out on falling edges, captures on rising
`timescale 1ns/10ps
`default_nettype none
module sps_peer (
    input wire logic sck,
    input wire logic mosi,
    input wire logic lsb,
    input wire logic load,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic [7:0] sh = 8'hFF;
    logic bitv;
    int n = 0;
    assign bitv = lsb ? sh[0] : sh[7];
    // Past the frame, show the inverse so a stale bit cannot pass
    assign miso = (n > 7) ? ~bitv : bitv;
    always @(posedge load) begin
        sh = tx;
        n = 0;
    end
    always @(posedge sck) begin
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        n = n + 1;
    end
    always @(negedge sck) if (n > 0 && n < 8) sh = lsb ? sh >> 1 : sh << 1;
endmodule // sps_peer
`default_nettype wire

// [bench/sps_port_tb.sv]
// Purpose: self-checking bench of the serial port
// Assumes: divider values kept small for short runs
// Notes: bench acts as master itself for the slave test
`timescale 1ns/10ps
`default_nettype none
module sps_port_tb;
    logic mclk = 0, rstn = 0, slave_mode_select = 0, master_clock_mode_bit = 0;
    logic bit_order_sel = 0, data_direction_bit = 0, auto_clear_enable = 0;
    logic serial_clock_out_enable = 1, mosi_out_enable = 1;
    logic miso_out_enable = 0, data_wr = 0, data_rd = 0, byte_flag_clr = 0;
    logic sck_i = 0, mosi_i = 0, slave_chip_select_n = 1, pload = 0;
    logic [7:0] clock_divider_reg = 8'h04, slave_preset_reg = 8'hA5;
    logic [7:0] data_wdata = 8'h00, ptx = 8'h00, prx, r, q, w, p, dv;
    wire [7:0] data_rdata;
    wire tx_fifo_count, rx_fifo_count, idle_flag, byte_complete_flag;
    wire sck_o, sck_oe, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
    int n_errors = 0, checks_done = 0, hi_cnt = 0, h0;
    // Divider, mode, bit order, written byte, far-end byte
    logic [25:0] rows [4] = '{{8'h04, 2'b00, 8'hA5, 8'h3C},
        {8'h08, 2'b01, 8'h96, 8'hE1}, {8'h04, 2'b10, 8'h0F, 8'hF0},
        {8'h06, 2'b11, 8'hFF, 8'h7E}}; // Dummy byte read
    sps_port DUT (.*);
    sps_peer u_peer (.sck(sck_o), .mosi(mosi_o), .lsb(bit_order_sel),
        .load(pload), .tx(ptx), .miso(miso_i), .rx(prx));
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) if (sck_o === 1'b1) hi_cnt <= hi_cnt + 1;
    // =========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_idle;
        int i;
        i = 0;
        while (idle_flag !== 1'b1 && i < 500) begin
            tick(1);
            i++;
        end
        if (i == 500) begin
            n_errors++;
            stop_test;
        end
    endtask
    task automatic wr(input logic [7:0] d);
        data_wdata = d;
        data_wr = 1;
        tick(1);
        data_wr = 0;
    endtask
    task automatic rd(output logic [7:0] d);
        data_rd = 1;
        tick(1);
        data_rd = 0;
        d = data_rdata;
    endtask
    // Bench plays the far master: mode 0, MSB first
    task automatic slave_byte(input logic [7:0] m, output logic [7:0] s);
        for (int b = 7; b >= 0; b--) begin
            mosi_i = m[b];
            tick(4);
            s = {s[6:0], miso_o};
            sck_i = 1;
            tick(4);
            sck_i = 0;
        end
        tick(4);
    endtask
    initial begin
        #400000;
        n_errors++;
        stop_test;
    end
    initial begin
        tick(8);
        chk(idle_flag, 1);
        chk({sck_o, byte_complete_flag, rx_fifo_count}, 0);
        chk(tx_fifo_count, 0);
        rstn = 1;
        tick(3);
        chk({sck_oe, mosi_oe, miso_oe}, 3'b110);
        foreach (rows[i]) begin
            {dv, master_clock_mode_bit, bit_order_sel, w, p} = rows[i];
            clock_divider_reg = dv;
            ptx = p;
            tick(2);
            pload = 1;
            tick(1);
            pload = 0;
            h0 = hi_cnt;
            wr(w);
            tick(3);
            wait_idle;
            chk(prx, w);
            if (!master_clock_mode_bit)
                chk(8'(hi_cnt - h0), 8'(8 * (dv >> 1)));
            chk({byte_complete_flag, rx_fifo_count}, 2'b11);
            rd(r);
            chk(r, p);
            chk(rx_fifo_count, 0);
            byte_flag_clr = 1;
            tick(1);
            byte_flag_clr = 0;
            chk(byte_complete_flag, 0);
            $display("master row %0d done", i);
        end
        wr(8'h11);
        tick(4);
        wr(8'h22);
        chk(tx_fifo_count, 1);
        tick(3);
        wait_idle;
        tick(3);
        wait_idle;
        chk({tx_fifo_count, prx}, 9'h022);
        rd(r);
        tick(1);
        chk(idle_flag, 1);
        data_direction_bit = 1;
        rd(r);
        tick(1);
        chk(idle_flag, 0);
        wait_idle;
        data_direction_bit = 0;
        chk(prx, 8'h22);
        auto_clear_enable = 1;
        chk(byte_complete_flag, 1);
        rd(r);
        chk(byte_complete_flag, 0);
        auto_clear_enable = 0;
        $display("queue, read start and auto clear done");
        slave_mode_select = 1;
        {master_clock_mode_bit, bit_order_sel} = 2'b00;
        serial_clock_out_enable = 0;
        mosi_out_enable = 0;
        miso_out_enable = 1;
        tick(2);
        chk({sck_oe, mosi_oe, miso_oe}, 0);
        slave_chip_select_n = 0;
        tick(2);
        chk({miso_oe, miso_o}, 2'b11);
        slave_byte(8'h3C, q);
        chk(q, 8'hA5);
        chk({byte_complete_flag, rx_fifo_count}, 2'b11);
        rd(r);
        chk(r, 8'h3C);
        wr(8'h5A);
        tick(1);
        chk(tx_fifo_count, 0);
        slave_byte(8'hC3, q);
        chk(q, 8'h5A);
        rd(r);
        chk(r, 8'hC3);
        slave_chip_select_n = 1;
        tick(1);
        chk(miso_oe, 0);
        $display("slave exchange done");
        stop_test;
    end
endmodule // sps_port_tb
`default_nettype wire
